// file: verilog/rpeoc_map.svh
`ifndef RPEOC_MAP_SVH
`define RPEOC_MAP_SVH
// ********************
// Register offsets
// ********************
`define RPEOC_OFF_PRIO_MAIN   12'h000
`define RPEOC_OFF_PRIO_AUX    12'h004
`define RPEOC_OFF_ETH_CFG     12'h008
`define RPEOC_OFF_SRC_SEL     12'h00C
// ********************
// Field positions and reset values
// ********************
`define RPEOC_PRIO_MSB        3
`define RPEOC_SRC_SEL_BIT     4
`define RPEOC_ETH_ALIGN_BIT   7
`define RPEOC_ETH_PLLOFF_BIT  6
`define RPEOC_ETH_OUT1_BIT    5
`define RPEOC_ETH_OUT4_BIT    4
`define RPEOC_ETH_OUT3_BIT    2
`define RPEOC_ETH_OUT2_BIT    1
`define RPEOC_ETH_MASK        8'hF6
`define RPEOC_PRIO_RESET      4'h0
`define RPEOC_ETH_RESET       8'h00
`endif

// file: verilog/rpeoc_pkg.sv
package rpeoc_pkg;
    // Register selected by an APB address
    typedef enum logic [2:0] {
        RPEOC_SEL_NONE = 3'b000,
        RPEOC_SEL_PMAIN = 3'b001,
        RPEOC_SEL_PAUX = 3'b010,
        RPEOC_SEL_ETH = 3'b011,
        RPEOC_SEL_SRC = 3'b100
    } rpeoc_sel_t;
endpackage

// file: verilog/rpeoc_prio_reg.sv
`timescale 1ns/10ps
`include "rpeoc_map.svh"
// ********************
// One 4-bit priority holder
// ********************
module rpeoc_prio_reg (
    input  wire logic       pclk,     // Bus clock
    input  wire logic       presetn,  // Async reset, low
    input  wire logic       wr_en,    // Write strobe
    input  wire logic [3:0] wr_data,  // New priority
    output logic      [3:0] prio,     // Stored priority
    output logic            enabled   // Candidate for selection
);
    logic [3:0] prio_q;
    logic [3:0] prio_d;

    // Next value
    always_comb begin
        prio_d = prio_q;
        if (wr_en) begin
            prio_d = wr_data; // [RL1]
        end
    end

    // Register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_q <= `RPEOC_PRIO_RESET;
        end else begin
            prio_q <= prio_d;
        end
    end

    // Zero removes the input from automatic selection
    assign prio = prio_q;
    assign enabled = (prio_q != 4'h0); // [RL2]

    // A written zero must drop the input, any other value keep it
    AST_ZERO_EXCL: assert property ( // [RL2]
        @(posedge pclk) disable iff (!presetn)
        wr_en |=> enabled == ($past(wr_data) != 4'h0))
        else $error("zero priority not excluded");
    AST_WR_TAKES: assert property ( // [RL1]
        @(posedge pclk) disable iff (!presetn)
        wr_en |=> prio == $past(wr_data))
        else $error("priority write lost");
endmodule

// file: verilog/rpeoc_top.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "rpeoc_map.svh"
// Function
// (RL1) Hold 4-bit priority of input four; smaller nonzero wins.
// (RL2) Priority zero excludes input four; 1..15 makes it a candidate.
// (RL3) Path select bit 4: 0 writes main path, 1 writes auxiliary.
// (RL4) Ethernet config bit 7 enables two kHz alignment of Ethernet clocks.
// (RL5) Ethernet config bit 6 set turns the Ethernet analog PLL off.
// (RL6) Ethernet config bit 5 selects Ethernet frequency for output one.
// (RL7) Bits 4, 2, 1 select Ethernet frequency for outputs four, three, two.
// (RL8) Unused bits ignore writes and read as zero.
module rpeoc_top
    import rpeoc_pkg::*;
(
    input  wire logic        pclk,                  // 10 MHz clock
    input  wire logic        presetn,               // Async reset, low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB access phase
    input  wire logic        pwrite,                // APB write
    input  wire logic [11:0] paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    output logic      [3:0]  main_input4_priority,  // Main path priority
    output logic             main_input4_enabled,   // Main path candidate
    output logic      [3:0]  aux_input4_priority,   // Aux path priority
    output logic             aux_input4_enabled,    // Aux path candidate
    output logic             path_priority_select,  // Path select bit
    output logic             eth_frame_align_enable,// Two kHz alignment
    output logic             eth_pll_power_down,    // Ethernet PLL off
    output logic             out1_eth_select,       // Output one Ethernet
    output logic             out2_eth_select,       // Output two Ethernet
    output logic             out3_eth_select,       // Output three Ethernet
    output logic             out4_eth_select        // Output four Ethernet
);
    // ********************
    // Address decode
    // ********************
    function automatic rpeoc_sel_t decode(input logic [11:0] a);
        case (a)
            `RPEOC_OFF_PRIO_MAIN: decode = RPEOC_SEL_PMAIN;
            `RPEOC_OFF_PRIO_AUX:  decode = RPEOC_SEL_PAUX;
            `RPEOC_OFF_ETH_CFG:   decode = RPEOC_SEL_ETH;
            `RPEOC_OFF_SRC_SEL:   decode = RPEOC_SEL_SRC;
            default:              decode = RPEOC_SEL_NONE;
        endcase
    endfunction

    rpeoc_sel_t sel;
    logic       wr_acc;
    logic       prio_wr;
    logic       main_wr;
    logic       aux_wr;
    logic [7:0] eth_q;
    logic [7:0] eth_d;
    logic       src_q;
    logic       src_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Zero-wait slave: every access completes in its first access cycle
    assign sel = decode(paddr);
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc = psel & penable & pwrite;

    // ********************
    // Path-steered priority writes
    // ********************
    // The priority word at offset 0 lands in the path the select bit names;
    // offset 4 reads back the auxiliary copy so both stay visible.
    assign prio_wr = wr_acc & (sel == RPEOC_SEL_PMAIN);
    assign main_wr = (prio_wr & ~src_q) ; // [RL3]
    assign aux_wr  = (prio_wr & src_q) | (wr_acc & (sel == RPEOC_SEL_PAUX));

    rpeoc_prio_reg u_main (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (main_wr),
        .wr_data (pwdata[`RPEOC_PRIO_MSB:0]),
        .prio    (main_input4_priority),
        .enabled (main_input4_enabled)
    );
    rpeoc_prio_reg u_aux (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (aux_wr),
        .wr_data (pwdata[`RPEOC_PRIO_MSB:0]),
        .prio    (aux_input4_priority),
        .enabled (aux_input4_enabled)
    );

    // ********************
    // Ethernet and source-select registers
    // ********************
    // Next values; unused Ethernet bits are never stored
    always_comb begin
        eth_d = eth_q;
        src_d = src_q;
        if (wr_acc && sel == RPEOC_SEL_ETH) begin
            eth_d = pwdata[7:0] & `RPEOC_ETH_MASK; // [RL8]
        end
        if (wr_acc && sel == RPEOC_SEL_SRC) begin
            src_d = pwdata[`RPEOC_SRC_SEL_BIT]; // [RL3]
        end
    end

    // Registers; reset leaves all Ethernet routing off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eth_q <= `RPEOC_ETH_RESET;
            src_q <= 1'b0;
        end else begin
            eth_q <= eth_d;
            src_q <= src_d;
        end
    end

    // Control outputs straight from flops
    assign path_priority_select = src_q;
    assign eth_frame_align_enable = eth_q[`RPEOC_ETH_ALIGN_BIT]; // [RL4]
    assign eth_pll_power_down = eth_q[`RPEOC_ETH_PLLOFF_BIT]; // [RL5]
    assign out1_eth_select = eth_q[`RPEOC_ETH_OUT1_BIT]; // [RL6]
    assign out4_eth_select = eth_q[`RPEOC_ETH_OUT4_BIT]; // [RL7]
    assign out3_eth_select = eth_q[`RPEOC_ETH_OUT3_BIT]; // [RL7]
    assign out2_eth_select = eth_q[`RPEOC_ETH_OUT2_BIT]; // [RL7]

    // ********************
    // Read data
    // ********************
    // Registered in setup so data is stable through the access cycle
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (sel)
                RPEOC_SEL_PMAIN: begin
                    rdata_d = {28'h000_0000, main_input4_priority}; // [RL8]
                end
                RPEOC_SEL_PAUX: begin
                    rdata_d = {28'h000_0000, aux_input4_priority};
                end
                RPEOC_SEL_ETH: begin
                    rdata_d = {24'h00_0000, eth_q};
                end
                RPEOC_SEL_SRC: begin
                    rdata_d = {27'h000_0000, src_q, 4'h0};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end else if (psel && penable) begin
            rdata_d = rdata_q;
        end
    end

    // Read word, back to zero once the access ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign prdata = rdata_q;

    // ********************
    // Checks
    // ********************
    // Named bus events; the properties below other than AST_UNUSED_ZERO are built from them
    sequence s_eth_write;
        wr_acc && sel == RPEOC_SEL_ETH;
    endsequence
    sequence s_main_prio_write;
        prio_wr && !src_q;
    endsequence
    sequence s_aux_prio_write;
        prio_wr && src_q;
    endsequence
    sequence s_src_write;
        wr_acc && sel == RPEOC_SEL_SRC;
    endsequence
    sequence s_hole_write;
        wr_acc && sel == RPEOC_SEL_NONE;
    endsequence
    sequence s_main_rd_setup;
        psel && !penable && !pwrite && sel == RPEOC_SEL_PMAIN;
    endsequence

    AST_UNUSED_ZERO: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        (eth_q & ~`RPEOC_ETH_MASK) == 8'h00)
        else $error("unused Ethernet bit set");
    AST_ETH_ALIGN: assert property ( // [RL4]
        @(posedge pclk) disable iff (!presetn)
        s_eth_write |=> eth_frame_align_enable == $past(pwdata[7]))
        else $error("alignment bit not taken");
    AST_ETH_PLL: assert property ( // [RL5]
        @(posedge pclk) disable iff (!presetn)
        s_eth_write |=> eth_pll_power_down == $past(pwdata[6]))
        else $error("PLL disable bit not taken");
    AST_OUT1: assert property ( // [RL6]
        @(posedge pclk) disable iff (!presetn)
        s_eth_write |=> out1_eth_select == $past(pwdata[5]))
        else $error("output one select not taken");
    AST_OUT432: assert property ( // [RL7]
        @(posedge pclk) disable iff (!presetn)
        s_eth_write |=> {out4_eth_select, out3_eth_select, out2_eth_select}
            == {$past(pwdata[4]), $past(pwdata[2]), $past(pwdata[1])})
        else $error("output four..two select not taken");
    AST_MAIN_PATH: assert property ( // [RL3]
        @(posedge pclk) disable iff (!presetn)
        s_main_prio_write |=> $stable(aux_input4_priority))
        else $error("main-path write touched aux");
    AST_AUX_PATH: assert property ( // [RL3]
        @(posedge pclk) disable iff (!presetn)
        s_aux_prio_write |=> $stable(main_input4_priority))
        else $error("aux-path write touched main");
    AST_MAIN_TAKES: assert property ( // [RL1]
        @(posedge pclk) disable iff (!presetn)
        s_main_prio_write
        |=> main_input4_priority == $past(pwdata[`RPEOC_PRIO_MSB:0]))
        else $error("main-path priority not taken");
    AST_SRC_SEL: assert property ( // [RL3]
        @(posedge pclk) disable iff (!presetn)
        s_src_write
        |=> path_priority_select == $past(pwdata[`RPEOC_SRC_SEL_BIT]))
        else $error("path select bit not taken");
    // Holes swallow writes, so nothing may move after one
    AST_HOLE_IGNORED: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        s_hole_write |=> $stable(eth_q) && $stable(src_q)
            && $stable(main_input4_priority) && $stable(aux_input4_priority))
        else $error("write to unmapped address changed state");
    AST_PRIO_RD: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        s_main_rd_setup |=> prdata[31:4] == 28'h000_0000)
        else $error("priority upper bits not zero");
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
// ********************
// Bench for the configuration registers
// ********************
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", nm, ex, got); \
    end end
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd_s, rd;
    logic        pready, pslverr, me, ae, ps, fa, pd, o1, o2, o3, o4;
    logic [3:0]  mp, ap;
    int          miscompares = 0, n_tests = 0;
    int          m_main, m_aux, m_eth, m_sel, sd;
    // Mapped offsets plus two holes; holes must read zero and ignore writes
    logic [11:0] addrs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                               12'h010, 12'hFFC};
    rpeoc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_input4_priority(mp), .main_input4_enabled(me),
        .aux_input4_priority(ap), .aux_input4_enabled(ae),
        .path_priority_select(ps), .eth_frame_align_enable(fa),
        .eth_pll_power_down(pd), .out1_eth_select(o1),
        .out2_eth_select(o2), .out3_eth_select(o3), .out4_eth_select(o4));
    // Clock, 100 ns period
    always #50 pclk = ~pclk;
    // Read data taken only at the completing edge, avoiding update races
    always @(posedge pclk) if (psel && penable && pready) rd_s <= prdata;
    // Closing verdict
    task automatic report_and_stop();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for ready; only the watchdog ends a wait that never ends
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        rd = rd_s;
    endtask
    // Output pins against the model
    task automatic chk_outs();
        `CHK("main_prio", m_main[3:0], mp)
        `CHK("main_en", m_main != 0, me)
        `CHK("aux_prio", m_aux[3:0], ap)
        `CHK("aux_en", m_aux != 0, ae)
        `CHK("sel", m_sel[0], ps)
        `CHK("align", m_eth[7], fa)
        `CHK("pll_off", m_eth[6], pd)
        `CHK("out1", m_eth[5], o1)
        `CHK("out432", {m_eth[4], m_eth[2], m_eth[1]}, {o4, o3, o2})
    endtask
    // Access plus model update and checks
    task automatic op(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
        int ex;
        apb(wr, a, d);
        ex = a == 0 ? m_main : a == 4 ? m_aux : a == 8 ? m_eth :
             a == 12 ? m_sel << 4 : 0;
        `CHK("slverr", 1'b0, pslverr)
        if (!wr) `CHK("rdata", ex, rd)
        if (wr && a == 0 && m_sel == 0) m_main = d & 15;
        if (wr && a == 0 && m_sel == 1) m_aux = d & 15;
        if (wr && a == 4) m_aux = d & 15;
        if (wr && a == 8) m_eth = d & 'hF6;
        if (wr && a == 12) m_sel = (d >> 4) & 1;
        chk_outs();
    endtask
    // Main sequence
    initial begin
        sd = $urandom(44);
        m_main = 0; m_aux = 0; m_eth = 0; m_sel = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (addrs[i]) op(0, addrs[i], 0);
        // Path select steering, all-ones writes, exclusion by zero
        op(1, 12'h000, 32'hFFFF_FFFF);
        op(1, 12'h00C, 32'hFFFF_FFFF);
        op(1, 12'h000, 32'h0000_0003);
        op(0, 12'h000, 0);
        op(0, 12'h004, 0);
        op(1, 12'h000, 32'h0000_0000);
        op(1, 12'h00C, 32'hFFFF_FFEF);
        op(1, 12'h000, 32'h0000_0001);
        op(1, 12'h008, 32'hFFFF_FFFF);
        op(0, 12'h008, 0);
        // Walk each Ethernet config bit alone
        for (int i = 0; i < 8; i++) begin
            op(1, 12'h008, 32'(1) << i);
            op(0, 12'h008, 0);
        end
        // Random mixed traffic including holes
        repeat (300) op(1'($urandom % 2), addrs[$urandom % 6], $urandom);
        // Reset in mid-run clears everything
        presetn <= 0;
        repeat (2) @(posedge pclk);
        m_main = 0; m_aux = 0; m_eth = 0; m_sel = 0;
        chk_outs();
        presetn <= 1;
        @(posedge pclk);
        foreach (addrs[i]) op(0, addrs[i], 0);
        report_and_stop();
    end
    // Watchdog, far beyond the expected run of about 1000 cycles
    initial begin
        #(100 * 20000);
        miscompares++;
        report_and_stop();
    end
endmodule
